// ---- core/stc_defs.vh ----
// constants for the standard timer capture input block
// What this block does
// - operating mode field value 01 selects capture input operation.
// - capture trigger from either pin, edge chosen by pin function field.
// - counter starts when timer_run goes from low to high.
// - each active edge while timer_run is high copies counter into capture register and raises request.
// - counter runs freely regardless of pins until timer_run falls.
// - period compare match resets counter to zero.
// - period compare match also raises an interrupt request.
// - pin function 11 disables capture while counter keeps running.
// - clear source and duty/period swap bits are ignored in capture operation.
// - pins configured as outputs are still sensed for captures.
// - no timer output driven; initial level and polarity bits unused.
// - period register zero lets counter run to its maximum before wrapping.
// - counter is 16 bits, wrapping from all ones to zero.
`ifndef STC_DEFS_VH
`define STC_DEFS_VH
`define STC_AW 3
`define STC_DW 16
`define STC_CNT_W 16
`define STC_PER_W 8
// register offsets
`define STC_REG_CTRL 3'h0
`define STC_REG_PERIOD 3'h1
`define STC_REG_CAPTURE 3'h2
`define STC_REG_COUNT 3'h3
`define STC_REG_STATUS 3'h4
`define STC_REG_ENABLE 3'h5
`define STC_REG_CLEAR 3'h6
// control register fields
`define STC_RUN_BIT 0
`define STC_MODE_LO 1
`define STC_MODE_HI 2
`define STC_PF_LO 3
`define STC_PF_HI 4
`define STC_CCLR_BIT 5
`define STC_DPX_BIT 6
`define STC_OC_BIT 7
`define STC_POL_BIT 8
`define STC_CTRL_W 9
`define STC_CTRL_RST 9'h000
`define STC_MODE_CAPTURE 2'h1
// pin function edge codes
`define STC_EDGE_RISE 2'h0
`define STC_EDGE_FALL 2'h1
`define STC_EDGE_BOTH 2'h2
`define STC_EDGE_NONE 2'h3
// status bits
`define STC_ST_CAP 0
`define STC_ST_PER 1
`define STC_ST_W 2
`endif

// ---- core/stc_edge.v ----
// edge detector on a synchronised level, selected by pin function
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_edge (
    input wire clock,
    input wire reset,
    input wire level,
    input wire [1:0] pin_func,
    output wire hit
);
    reg prev_r;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            prev_r <= 1'b0;
        end else begin
            prev_r <= level;
        end
    end
    wire rise = level & ~prev_r;
    wire fall = ~level & prev_r;
    // 11 yields no trigger at all
    assign hit = (pin_func == `STC_EDGE_RISE) ? rise :
                 (pin_func == `STC_EDGE_FALL) ? fall :
                 (pin_func == `STC_EDGE_BOTH) ? (rise | fall) : 1'b0;
endmodule

// ---- core/stc_sync.v ----
// two flop synchroniser for one pin
`timescale 1ns/1ps
module stc_sync (
    input wire clock,
    input wire reset,
    input wire din,
    output wire dout
);
    reg meta_r;
    reg sync_r;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end
    assign dout = sync_r;
endmodule

// ---- core/stc_top.v ----
// standard timer capture input mode with register port and interrupt
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "stc_defs.vh"
module stc_top (
    input wire clock,
    input wire reset,
    input wire [`STC_AW-1:0] reg_addr,
    input wire [`STC_DW-1:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [`STC_DW-1:0] reg_rdata,
    input wire capture_pin_a,
    input wire capture_pin_b,
    output wire capture_match_flag,
    output wire period_match_flag,
    output wire irq
);
    // ====================================================================
    // registers
    // ====================================================================
    reg [`STC_CTRL_W-1:0] timer_ctrl_one_r;
    reg [`STC_PER_W-1:0] period_compare_reg_r;
    reg [`STC_CNT_W-1:0] capture_value_reg_r;
    reg [`STC_CNT_W-1:0] count_r;
    reg [`STC_ST_W-1:0] status_r;
    reg [`STC_ST_W-1:0] enable_r;
    reg run_d_r;

    wire timer_run = timer_ctrl_one_r[`STC_RUN_BIT];
    wire op_mode_lo = timer_ctrl_one_r[`STC_MODE_LO];
    wire op_mode_hi = timer_ctrl_one_r[`STC_MODE_HI];
    wire pin_func_lo = timer_ctrl_one_r[`STC_PF_LO];
    wire pin_func_hi = timer_ctrl_one_r[`STC_PF_HI];
    wire capture_mode = ({op_mode_hi, op_mode_lo} == `STC_MODE_CAPTURE);
    // clear_source_sel, duty_period_swap, output_init_level and output_polarity
    // are stored for readback only; nothing here reads them

    function is_write;
        input [`STC_AW-1:0] a;
        begin
            is_write = reg_write && (reg_addr == a);
        end
    endfunction

    // ====================================================================
    // pin sensing
    // ====================================================================
    // pins are sensed whatever their port direction elsewhere
    wire pin_a_s;
    wire pin_b_s;
    wire hit_a;
    wire hit_b;
    stc_sync u_sync_a (
        .clock(clock),
        .reset(reset),
        .din(capture_pin_a),
        .dout(pin_a_s)
    );
    stc_sync u_sync_b (
        .clock(clock),
        .reset(reset),
        .din(capture_pin_b),
        .dout(pin_b_s)
    );
    stc_edge u_edge_a (
        .clock(clock),
        .reset(reset),
        .level(pin_a_s),
        .pin_func({pin_func_hi, pin_func_lo}),
        .hit(hit_a)
    );
    stc_edge u_edge_b (
        .clock(clock),
        .reset(reset),
        .level(pin_b_s),
        .pin_func({pin_func_hi, pin_func_lo}),
        .hit(hit_b)
    );
    wire cap_ev = capture_mode && timer_run && (hit_a || hit_b);

    // ====================================================================
    // counter
    // ====================================================================
    wire run_rise = timer_run && !run_d_r;
    // zero period never matches so the counter wraps at all ones
    wire per_match = capture_mode && timer_run && (period_compare_reg_r != 8'h00) &&
                     (count_r[`STC_CNT_W-1:`STC_CNT_W-`STC_PER_W] ==
                      period_compare_reg_r) && (count_r[`STC_CNT_W-`STC_PER_W-1:0] == 8'h00);
    reg [`STC_CNT_W-1:0] count_nxt;
    always @* begin
        count_nxt = count_r;
        if (run_rise) begin
            count_nxt = {`STC_CNT_W{1'b0}};
        end else if (timer_run && per_match) begin
            count_nxt = {`STC_CNT_W{1'b0}};
        end else if (timer_run) begin
            count_nxt = count_r + 16'h0001;
        end
    end

    always @(posedge clock or posedge reset) begin
        if (reset) begin
            count_r <= {`STC_CNT_W{1'b0}};
            run_d_r <= 1'b0;
            capture_value_reg_r <= {`STC_CNT_W{1'b0}};
        end else begin
            count_r <= count_nxt;
            run_d_r <= timer_run;
            if (cap_ev) begin
                capture_value_reg_r <= count_r;
            end
        end
    end

    // ====================================================================
    // software registers and sticky flags
    // ====================================================================
    wire [`STC_ST_W-1:0] set_bits = {per_match, cap_ev};
    wire [`STC_ST_W-1:0] clr_bits = is_write(`STC_REG_CLEAR) ?
                                    reg_wdata[`STC_ST_W-1:0] : {`STC_ST_W{1'b0}};
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            timer_ctrl_one_r <= `STC_CTRL_RST;
            period_compare_reg_r <= {`STC_PER_W{1'b0}};
            status_r <= {`STC_ST_W{1'b0}};
            enable_r <= {`STC_ST_W{1'b0}};
        end else begin
            if (is_write(`STC_REG_CTRL)) begin
                timer_ctrl_one_r <= reg_wdata[`STC_CTRL_W-1:0];
            end
            if (is_write(`STC_REG_PERIOD)) begin
                period_compare_reg_r <= reg_wdata[`STC_PER_W-1:0];
            end
            if (is_write(`STC_REG_ENABLE)) begin
                enable_r <= reg_wdata[`STC_ST_W-1:0];
            end
            // set wins over clear
            status_r <= (status_r & ~clr_bits) | set_bits;
        end
    end

    assign capture_match_flag = status_r[`STC_ST_CAP];
    assign period_match_flag = status_r[`STC_ST_PER];
    assign irq = |(status_r & enable_r);

    // ====================================================================
    // read port
    // ====================================================================
    reg [`STC_DW-1:0] rd_mux;
    always @* begin
        rd_mux = {`STC_DW{1'b0}};
        case (reg_addr)
            `STC_REG_CTRL: rd_mux = {7'h00, timer_ctrl_one_r};
            `STC_REG_PERIOD: rd_mux = {8'h00, period_compare_reg_r};
            `STC_REG_CAPTURE: rd_mux = capture_value_reg_r;
            `STC_REG_COUNT: rd_mux = count_r;
            `STC_REG_STATUS: rd_mux = {14'h0000, status_r};
            `STC_REG_ENABLE: rd_mux = {14'h0000, enable_r};
            default: rd_mux = {`STC_DW{1'b0}};
        endcase
    end
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata <= {`STC_DW{1'b0}};
        end else if (reg_read) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= {`STC_DW{1'b0}};
        end
    end
endmodule

// ---- tb/stc_props.sv ----
// port assertions for the capture timer
`timescale 1ns/1ps
module stc_props (
    input wire clock,
    input wire reset,
    input wire [2:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    input wire [15:0] reg_rdata,
    input wire capture_pin_a,
    input wire capture_pin_b,
    input wire capture_match_flag,
    input wire period_match_flag,
    input wire irq
);
    reg [4:0] ctl_r;
    reg [7:0] per_r;
    reg [1:0] en_r;
    wire wr6 = reg_write && reg_addr == 3'h6;
    wire pin = capture_pin_a | capture_pin_b;
    wire cap_en = ctl_r[2:0] == 3'h3;
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            ctl_r <= 5'h00;
            per_r <= 8'h00;
            en_r <= 2'h0;
        end else if (reg_write) begin
            if (reg_addr == 3'h0) ctl_r <= reg_wdata[4:0];
            if (reg_addr == 3'h1) per_r <= reg_wdata[7:0];
            if (reg_addr == 3'h5) en_r <= reg_wdata[1:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    irq_level_a: assert property (irq == |({period_match_flag, capture_match_flag} & en_r))
        else $error("irq mismatch");
    cap_sticky_a: assert property (capture_match_flag && !(wr6 && reg_wdata[0]) |=> capture_match_flag)
        else $error("capture flag dropped");
    per_sticky_a: assert property (period_match_flag && !(wr6 && reg_wdata[1]) |=> period_match_flag)
        else $error("period flag dropped");
    cap_cause_a: assert property ($rose(capture_match_flag) |-> $past(cap_en) && $past(ctl_r[4:3]) != 2'h3)
        else $error("capture while disabled");
    per_cause_a: assert property ($rose(period_match_flag) |-> $past(cap_en) && $past(per_r) != 8'h00)
        else $error("period flag unexpected");
    cap_rise_a: assert property (cap_en && !ctl_r[3] && !ctl_r[4] && $rose(pin) |-> ##[1:4] capture_match_flag)
        else $error("rise not captured");
    cap_fall_a: assert property (cap_en && ctl_r[4] != ctl_r[3] && $fell(pin) |-> ##[1:4] capture_match_flag)
        else $error("fall not captured");
    stat_read_a: assert property (reg_read && reg_addr == 3'h4 |=> reg_rdata[1:0] == $past({period_match_flag, capture_match_flag}))
        else $error("status read wrong");
    cap_seen_c: cover property ($rose(capture_match_flag));
    per_seen_c: cover property ($rose(period_match_flag));
    irq_seen_c: cover property ($rose(irq));
endmodule

// ---- tb/stc_src.sv ----
// external pulse source driving one capture pin
`timescale 1ns/1ps
module stc_src (
    input wire clock,
    input wire reset,
    input wire lvl,
    input wire slow,
    output reg pin
);
    reg [2:0] dly_r;
    // slow mode lags the requested level by four clocks, three more than fast mode
    always @(posedge clock or posedge reset) begin
        if (reset) begin
            dly_r <= 3'h0;
            pin <= 1'b0;
        end else begin
            dly_r <= {dly_r[1:0], lvl};
            pin <= slow ? dly_r[2] : lvl;
        end
    end
endmodule

// ---- tb/stc_tb_top.sv ----
// self-checking bench for the capture timer
`timescale 1ns/1ps
module stc_tb_top;
    reg clock = 1'b0;
    reg reset = 1'b1;
    reg [2:0] reg_addr = 3'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_write = 1'b0;
    reg reg_read = 1'b0;
    reg lvl_a = 1'b0;
    reg lvl_b = 1'b0;
    reg slow = 1'b0;
    wire [15:0] reg_rdata;
    wire capture_pin_a, capture_pin_b, capture_match_flag, period_match_flag, irq;
    integer fail_count = 0;
    integer compares = 0;
    integer cyc = 0;
    reg [15:0] v;
    reg [15:0] c1;
    stc_top i_dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .capture_pin_a, .capture_pin_b, .capture_match_flag, .period_match_flag, .irq);
    stc_src i_sa (.clock, .reset, .lvl(lvl_a), .slow, .pin(capture_pin_a));
    stc_src i_sb (.clock, .reset, .lvl(lvl_b), .slow, .pin(capture_pin_b));
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    task chk(input string nm, input [15:0] e, input [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task wr(input [2:0] a, input [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        @(posedge clock);
    endtask
    task rd(input [2:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clock);
    endtask
    task tog(input s, input x);
        if (s) lvl_b <= x;
        else lvl_a <= x;
        repeat (8) @(posedge clock);
    endtask
    task t_regs;
        reg [3:0] a;
        wr(3'h7, 16'hFFFF);
        for (a = 0; a < 8; a = a + 1) begin
            rd(a[2:0]);
            chk("reset value", 16'h0000, v);
        end
        $display("regs done");
    endtask
    task t_edges;
        reg [15:0] p;
        for (p = 0; p < 3; p = p + 1) begin
            slow <= (p == 16'h2);
            wr(3'h0, 16'h01E3 | (p << 3));
            wr(3'h6, 16'h0003);
            rd(3'h3);
            c1 = v;
            tog(p == 16'h1, 1'b1);
            chk("rise", {15'h0, p != 16'h1}, {15'h0, capture_match_flag});
            rd(3'h2);
            if (p == 16'h0) chk("cap", 16'h1, {15'h0, v - c1 > 16'd1 && v - c1 < 16'd10});
            wr(3'h6, 16'h0003);
            tog(p == 16'h1, 1'b0);
            chk("fall", {15'h0, p != 16'h0}, {15'h0, capture_match_flag});
        end
        $display("edges done");
    endtask
    task t_none(input [15:0] c);
        wr(3'h0, c);
        wr(3'h6, 16'h0003);
        tog(1'b0, 1'b1);
        tog(1'b0, 1'b0);
        chk("no capture", 16'h0, {15'h0, capture_match_flag});
        rd(3'h3);
        c1 = v;
        rd(3'h3);
        chk("runs", 16'h1, {15'h0, v != c1});
        $display("none done");
    endtask
    task t_period;
        wr(3'h1, 16'h0001);
        wr(3'h0, 16'h0002);
        wr(3'h6, 16'h0003);
        wr(3'h0, 16'h0003);
        repeat (240) @(posedge clock);
        chk("early", 16'h0, {15'h0, period_match_flag});
        repeat (30) @(posedge clock);
        chk("wrap flag", 16'h1, {15'h0, period_match_flag});
        rd(3'h3);
        chk("wrapped", 16'h1, {15'h0, v < 16'h0020});
        wr(3'h5, 16'h0002);
        chk("irq on", 16'h1, {15'h0, irq});
        wr(3'h5, 16'h0000);
        chk("irq off", 16'h0, {15'h0, irq});
        wr(3'h6, 16'h0002);
        chk("cleared", 16'h0, {15'h0, period_match_flag});
        wr(3'h0, 16'h0002);
        rd(3'h3);
        c1 = v;
        rd(3'h3);
        chk("held", c1, v);
        $display("period done");
    endtask
    task t_wrap;
        wr(3'h1, 16'h0000);
        wr(3'h0, 16'h0003);
        repeat (65536) @(posedge clock);
        rd(3'h3);
        chk("full wrap", 16'h1, {15'h0, v < 16'h0008});
        chk("no flag", 16'h0, {15'h0, period_match_flag});
        $display("wrap done");
    endtask
    task complete_run;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        t_regs;
        t_edges;
        t_none(16'h001B);
        t_none(16'h0001);
        t_period;
        t_wrap;
        complete_run;
    end
endmodule
bind stc_top stc_props i_props (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .capture_pin_a, .capture_pin_b, .capture_match_flag, .period_match_flag, .irq);
